//--- hw/spsr_consts.svh
// Constants for the serial/parallel-in shift register block
`ifndef SPSR_CONSTS_SVH
`define SPSR_CONSTS_SVH

`define SPSR_WIDTH 16
`define SPSR_LAST 15
`define SPSR_CNT_W 5
`define SPSR_FULL_CNT 5'h10
`define SPSR_WORD_LAST_CNT 5'h0F
`define SPSR_FIFO_DEPTH 8
`define SPSR_SYNC_W 21
`define SPSR_CLK_PERIOD_NS 10
`define SPSR_STAGE_RESET 16'h0000

`endif

//--- hw/spsr_pkg.sv
// Types shared by the shift register block
`default_nettype none

package spsr_pkg;

    typedef enum logic [1:0] {
        SPSR_HOLD,
        SPSR_SER_LOAD,
        SPSR_SER_OUT,
        SPSR_PAR_LOAD
    } spsr_mode_t;

    typedef struct packed {
        logic shift_clock_n;
        logic device_select_n;
        logic direction_select;
        logic function_pick;
        logic serial_in;
        logic [15:0] parallel_in;
    } spsr_pins_t;

endpackage : spsr_pkg

`default_nettype wire

//--- hw/spsr_sync.sv
// Three-flop input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module spsr_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;
    logic [WIDTH-1:0] out_r;
    logic [WIDTH-1:0] out_nxt;

    // A bit changes only once the second and third flops agree
    always_comb
    begin
        out_nxt = (s2_r & s3_r) | (out_r & (s2_r | s3_r));
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            out_r <= '0;
        end
        else
        begin
            s1_r <= async_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            out_r <= out_nxt;
        end
    end

    assign sync_out = out_r;

endmodule : spsr_sync

`default_nettype wire

//--- hw/spsr_fifo.sv
// Word FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module spsr_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_r;
    logic [AW-1:0] wr_nxt;
    logic [AW-1:0] rd_r;
    logic [AW-1:0] rd_nxt;
    logic [AW:0] cnt_r;
    logic [AW:0] cnt_nxt;
    logic push;
    logic pop;

    always_comb
    begin
        in_ready = (cnt_r != DEPTH[AW:0]);
        out_valid = (cnt_r != '0);
        push = in_valid & in_ready;
        pop = out_valid & out_ready;
        wr_nxt = push ? AW'(wr_r + 1'b1) : wr_r;
        rd_nxt = pop ? AW'(rd_r + 1'b1) : rd_r;
        cnt_nxt = cnt_r;
        if (push && !pop)
        begin
            cnt_nxt = (AW+1)'(cnt_r + 1'b1);
        end
        else if (pop && !push)
        begin
            cnt_nxt = (AW+1)'(cnt_r - 1'b1);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end
        else
        begin
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Storage needs no reset; out_valid guards every read
    always_ff @(posedge sys_clk)
    begin
        if (push)
        begin
            mem_r[wr_r] <= in_data;
        end
    end

    assign out_data = mem_r[rd_r];

endmodule : spsr_fifo

`default_nettype wire

//--- hw/spsr_top.sv
// Serial/parallel-in, serial-out 16-stage shift register
`timescale 1ns/1ps
`default_nettype none
`include "spsr_consts.svh"

// Overview of operation
// [RULE1] Sixteen stages, loaded serially or in parallel, unloaded serially.
// [RULE2] Select high: ignore clock, hold contents, serial pin undriven.
// [RULE3] Select low, direction low: falling edge shifts serial pin in.
// [RULE4] Serial output drives last stage and recirculates it to stage zero.
// [RULE5] Select low, direction high, pick low chooses serial output.
// [RULE6] Select low, direction high, pick high chooses parallel load.
// [RULE7] Parallel load copies all sixteen inputs on the falling edge.
// [RULE8] During parallel load the serial pin is driven with last stage.
// [RULE9] Controller keeps shift clock low while raising the select.
// [RULE10] Contents undefined until a full serial or parallel load.
module spsr_top (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Control pins
    input wire logic shift_clock_n,
    input wire logic device_select_n,
    input wire logic direction_select,
    input wire logic function_pick,
    // Data pins
    input wire logic [15:0] parallel_in,
    input wire logic serial_io_in,
    output logic serial_io_out,
    output logic serial_io_oe,
    // Received word stream
    output logic [15:0] word_data,
    output logic word_valid,
    input wire logic word_ready,
    // Status
    output logic stages_valid,
    output logic word_lost
);
    import spsr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Mode decode

    function automatic spsr_mode_t mode_of(input spsr_pins_t p);
        if (p.device_select_n)
        begin
            mode_of = SPSR_HOLD;
        end
        else if (!p.direction_select)
        begin
            mode_of = SPSR_SER_LOAD;
        end
        else if (!p.function_pick)
        begin
            // [RULE5] Serial output mode
            mode_of = SPSR_SER_OUT;
        end
        else
        begin
            // [RULE6] Parallel load mode
            mode_of = SPSR_PAR_LOAD;
        end
    endfunction : mode_of

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisation

    spsr_pins_t pins_raw;
    spsr_pins_t pin_q;
    logic [`SPSR_SYNC_W-1:0] pin_bits;

    // All pins share one delay, so their relative timing is kept
    assign pins_raw = '{
        shift_clock_n: shift_clock_n,
        device_select_n: device_select_n,
        direction_select: direction_select,
        function_pick: function_pick,
        serial_in: serial_io_in,
        parallel_in: parallel_in
    };

    spsr_sync #(
        .WIDTH(`SPSR_SYNC_W)
    ) u_sync (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .async_in(pins_raw),
        .sync_out(pin_bits)
    );

    assign pin_q = spsr_pins_t'(pin_bits);

    ////////////////////////////////////////////////////////////////////////
    // Shift register state

    logic prev_clk_r;
    logic prev_clk_nxt;
    logic [15:0] stage_r;
    logic [15:0] stage_nxt;
    logic [`SPSR_CNT_W-1:0] fill_r;
    logic [`SPSR_CNT_W-1:0] fill_nxt;
    logic [`SPSR_CNT_W-1:0] new_r;
    logic [`SPSR_CNT_W-1:0] new_nxt;
    logic pend_r;
    logic pend_nxt;
    logic [15:0] pend_data_r;
    logic [15:0] pend_data_nxt;
    logic lost_r;
    logic lost_nxt;
    logic fall;
    logic word_done;
    logic fifo_in_ready;
    spsr_mode_t mode;

    always_comb
    begin
        mode = mode_of(pin_q);
        // [RULE9] Falling edge only
        // A rising select with the clock high makes no edge here
        fall = prev_clk_r & ~pin_q.shift_clock_n;
        prev_clk_nxt = pin_q.shift_clock_n;
        stage_nxt = stage_r;
        fill_nxt = fill_r;
        new_nxt = new_r;
        word_done = 1'b0;
        if (fall)
        begin
            case (mode)
                SPSR_SER_LOAD:
                begin
                    // [RULE3] Serial capture shift
                    stage_nxt = {stage_r[`SPSR_LAST-1:0], pin_q.serial_in};
                    // [RULE10] Count filled stages
                    if (fill_r != `SPSR_FULL_CNT)
                    begin
                        fill_nxt = `SPSR_CNT_W'(fill_r + 1'b1);
                    end
                    // [RULE1] Sixteen bits per word
                    if (new_r == `SPSR_WORD_LAST_CNT)
                    begin
                        word_done = 1'b1;
                        new_nxt = '0;
                    end
                    else
                    begin
                        new_nxt = `SPSR_CNT_W'(new_r + 1'b1);
                    end
                end
                SPSR_SER_OUT:
                begin
                    // [RULE4] Recirculating shift
                    stage_nxt = {stage_r[`SPSR_LAST-1:0], stage_r[`SPSR_LAST]};
                    new_nxt = '0;
                end
                SPSR_PAR_LOAD:
                begin
                    // [RULE7] Parallel copy
                    stage_nxt = pin_q.parallel_in;
                    fill_nxt = `SPSR_FULL_CNT;
                    new_nxt = '0;
                end
                default:
                begin
                    // [RULE2] Hold contents
                    stage_nxt = stage_r;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Word hand-off toward the FIFO

    // A full FIFO stalls the hand-off; one more word waits, any word finished while it waits is lost
    always_comb
    begin
        pend_nxt = pend_r;
        pend_data_nxt = pend_data_r;
        lost_nxt = 1'b0;
        if (pend_r && fifo_in_ready)
        begin
            pend_nxt = 1'b0;
        end
        if (word_done)
        begin
            if (pend_r && !fifo_in_ready)
            begin
                lost_nxt = 1'b1;
            end
            else
            begin
                pend_nxt = 1'b1;
                pend_data_nxt = stage_nxt;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            prev_clk_r <= 1'b0;
            stage_r <= `SPSR_STAGE_RESET;
            fill_r <= '0;
            new_r <= '0;
            pend_r <= 1'b0;
            pend_data_r <= `SPSR_STAGE_RESET;
            lost_r <= 1'b0;
        end
        else
        begin
            prev_clk_r <= prev_clk_nxt;
            stage_r <= stage_nxt;
            fill_r <= fill_nxt;
            new_r <= new_nxt;
            pend_r <= pend_nxt;
            pend_data_r <= pend_data_nxt;
            lost_r <= lost_nxt;
        end
    end

    spsr_fifo #(
        .WIDTH(`SPSR_WIDTH),
        .DEPTH(`SPSR_FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .in_valid(pend_r),
        .in_ready(fifo_in_ready),
        .in_data(pend_data_r),
        .out_valid(word_valid),
        .out_ready(word_ready),
        .out_data(word_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // Serial pin driver and status

    // [RULE2] Driver off while deselected
    // [RULE5] Driven in serial output
    // [RULE8] Driven in parallel load
    assign serial_io_oe = ~pin_q.device_select_n & pin_q.direction_select;
    // [RULE4] Last stage on the pin
    assign serial_io_out = stage_r[`SPSR_LAST];
    // [RULE10] Known once full
    assign stages_valid = (fill_r == `SPSR_FULL_CNT);
    assign word_lost = lost_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    hold_driver_off_a: assert property ( // [RULE2]
        pin_q.device_select_n |-> !serial_io_oe)
        else $error("serial pin driven while deselected");

    hold_contents_a: assert property ( // [RULE2]
        (fall && pin_q.device_select_n) |=> $stable(stage_r))
        else $error("contents changed while deselected");

    serial_capture_a: assert property ( // [RULE3]
        (fall && mode == SPSR_SER_LOAD) |=>
        stage_r == {$past(stage_r[14:0]), $past(pin_q.serial_in)})
        else $error("serial load did not shift in pin");

    serial_in_float_a: assert property ( // [RULE3]
        (mode == SPSR_SER_LOAD) |-> !serial_io_oe)
        else $error("serial pin driven in serial load");

    recirc_shift_a: assert property ( // [RULE4]
        (fall && mode == SPSR_SER_OUT) |=>
        stage_r == {$past(stage_r[14:0]), $past(stage_r[15])})
        else $error("serial output did not recirculate");

    serial_out_drive_a: assert property ( // [RULE5]
        (mode == SPSR_SER_OUT) |-> serial_io_oe && serial_io_out == stage_r[15])
        else $error("serial output not driven from last stage");

    par_no_shift_a: assert property ( // [RULE6]
        (fall && mode == SPSR_PAR_LOAD) |=> stage_r == $past(pin_q.parallel_in))
        else $error("parallel load shifted instead");

    par_load_copy_a: assert property ( // [RULE7]
        (fall && mode == SPSR_PAR_LOAD) ##1 !fall |=> $stable(stage_r))
        else $error("parallel load contents moved without an edge");

    par_drive_a: assert property ( // [RULE8]
        (mode == SPSR_PAR_LOAD) |-> serial_io_oe && serial_io_out == stage_r[15])
        else $error("parallel load pin not showing last stage");

    par_fills_a: assert property ( // [RULE10]
        (fall && mode == SPSR_PAR_LOAD) |=> stages_valid)
        else $error("parallel load did not mark stages valid");

    word_push_a: assert property ( // [RULE1]
        (word_done && !(pend_r && !fifo_in_ready)) |=>
        pend_r && pend_data_r == $past(stage_nxt))
        else $error("complete word not handed to fifo");

endmodule : spsr_top

`default_nettype wire

//--- tb/spsr_ctrl.sv
// Controller model driving the shift register pins and serial line
`timescale 1ns/1ps
`default_nettype none

module spsr_ctrl (
    // Clock
    input wire logic sys_clk,
    // Control pins
    output logic shift_clock_n,
    output logic device_select_n,
    output logic direction_select,
    output logic function_pick,
    // Data pins
    output logic [15:0] parallel_in,
    output logic drv_en,
    output logic drv_val
);

    initial
    begin
        shift_clock_n = 1'b0;
        device_select_n = 1'b1;
        direction_select = 1'b0;
        function_pick = 1'b0;
        parallel_in = 16'h0000;
        drv_en = 1'b0;
        drv_val = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Select moves with clock low
    task automatic setup(input logic cs_n, input logic dir,
        input logic pick, input logic [15:0] par);
        @(posedge sys_clk);
        device_select_n <= cs_n;
        direction_select <= dir;
        function_pick <= pick;
        parallel_in <= par;
        drv_en <= !cs_n && !dir;
        repeat (6) @(posedge sys_clk);
        #1;
    endtask : setup

    // Pins are filtered, so each phase spans several system clocks
    task automatic tick(input logic b);
        @(posedge sys_clk);
        drv_val <= b;
        repeat (5) @(posedge sys_clk);
        shift_clock_n <= 1'b1;
        repeat (6) @(posedge sys_clk);
        shift_clock_n <= 1'b0;
        repeat (10) @(posedge sys_clk);
        #1;
    endtask : tick

endmodule : spsr_ctrl
`default_nettype wire

//--- tb/spsr_top_tb.sv
// Self-checking bench for the shift register block
`timescale 1ns/1ps
`default_nettype none

module spsr_top_tb;

    localparam int LIMIT = 20000;
    localparam logic [15:0] WORD_A = 16'hC3A5;
    localparam logic [15:0] WORD_B = 16'h9E61;
    logic sys_clk;
    logic rst_b;
    logic shift_clock_n, device_select_n, direction_select, function_pick;
    logic [15:0] parallel_in;
    logic [15:0] word_data;
    logic drv_en, drv_val, line;
    logic line_last = 1'b0;
    logic serial_io_out, serial_io_oe, word_valid, word_ready;
    logic stages_valid, word_lost;
    int n_fail = 0;
    int num_checks = 0;
    int n_lost = 0;
    int cycles = 0;

    spsr_top i_dut (
        .sys_clk(sys_clk), .rst_b(rst_b), .shift_clock_n(shift_clock_n),
        .device_select_n(device_select_n),
        .direction_select(direction_select), .function_pick(function_pick),
        .parallel_in(parallel_in), .serial_io_in(line),
        .serial_io_out(serial_io_out), .serial_io_oe(serial_io_oe),
        .word_data(word_data), .word_valid(word_valid),
        .word_ready(word_ready), .stages_valid(stages_valid),
        .word_lost(word_lost)
    );

    spsr_ctrl i_ctrl (
        .sys_clk(sys_clk), .shift_clock_n(shift_clock_n),
        .device_select_n(device_select_n),
        .direction_select(direction_select), .function_pick(function_pick),
        .parallel_in(parallel_in), .drv_en(drv_en), .drv_val(drv_val)
    );

    // Floating line flips so a stale level can never pass
    assign line = serial_io_oe ? serial_io_out : (drv_en ? drv_val : ~line_last);

    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk)
    begin
        line_last <= line;
        cycles++;
        if (cycles == LIMIT)
        begin
            n_fail++;
            complete_run();
        end
    end

    // Sampled mid-cycle, the pulse is settled there
    always @(negedge sys_clk)
    begin
        if (word_lost === 1'b1)
        begin
            n_lost++;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_bit

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_word

    function automatic logic [15:0] word_of(input int n);
        return 16'h5A3C + 16'(n * 16'h1357);
    endfunction : word_of

    task automatic load_word(input logic [15:0] w);
        i_ctrl.setup(1'b0, 1'b0, 1'b0, ~w);
        chk_bit(serial_io_oe, 1'b0);
        for (int i = 15; i >= 0; i--)
        begin
            i_ctrl.tick(w[i]);
        end
    endtask : load_word

    task automatic read_word(input logic [15:0] exp);
        i_ctrl.setup(1'b0, 1'b1, 1'b0, ~exp);
        chk_bit(serial_io_oe, 1'b1);
        chk_bit(serial_io_out, exp[15]);
        for (int k = 1; k <= 16; k++)
        begin
            i_ctrl.tick(1'b0);
            chk_bit(serial_io_out, exp[(31 - k) % 16]);
        end
    endtask : read_word

    task automatic pop(input logic [15:0] exp);
        int n;
        n = 0;
        while (word_valid !== 1'b1 && n < 50)
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        chk_bit(word_valid, 1'b1);
        chk_word(word_data, exp);
        @(posedge sys_clk);
        word_ready <= 1'b1;
        @(posedge sys_clk);
        word_ready <= 1'b0;
        #1;
    endtask : pop

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk_bit(serial_io_oe, 1'b0);
        chk_bit(stages_valid, 1'b0);
        chk_bit(word_valid, 1'b0);
    endtask : t_reset

    task automatic t_serial();
        load_word(WORD_A);
        chk_bit(stages_valid, 1'b1);
        pop(WORD_A);
        read_word(WORD_A);
        chk_bit(word_valid, 1'b0);
    endtask : t_serial

    task automatic t_parallel();
        i_ctrl.setup(1'b0, 1'b1, 1'b1, WORD_B);
        chk_bit(serial_io_oe, 1'b1);
        i_ctrl.tick(1'b0);
        chk_bit(serial_io_out, WORD_B[15]);
        chk_bit(word_valid, 1'b0);
        read_word(WORD_B);
    endtask : t_parallel

    task automatic t_hold();
        i_ctrl.setup(1'b1, 1'b1, 1'b1, ~WORD_B);
        chk_bit(serial_io_oe, 1'b0);
        repeat (3) i_ctrl.tick(1'b1);
        read_word(WORD_B);
    endtask : t_hold

    task automatic t_fill();
        for (int n = 0; n < 10; n++)
        begin
            load_word(word_of(n));
        end
        chk_word(16'(n_lost), 16'h0001);
        for (int n = 0; n < 9; n++)
        begin
            pop(word_of(n));
        end
        repeat (4) @(posedge sys_clk);
        #1;
        chk_bit(word_valid, 1'b0);
    endtask : t_fill

    task automatic complete_run();
        if (n_fail == 0 && num_checks > 0)
        begin
            $display("Test passed");
        end
        else
        begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run

    initial
    begin
        rst_b = 1'b0;
        word_ready = 1'b0;
        repeat (8) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge sys_clk);
        #1;
        t_reset();
        t_serial();
        t_parallel();
        t_hold();
        t_fill();
        complete_run();
    end

endmodule : spsr_top_tb
`default_nettype wire
